// ---- src/imp_regs.sv ----
// interrupt enable and priority registers with request gating and arbiter
`timescale 1ns/1ps
`default_nettype none
`include "imp_params.svh"

// Overview of operation
// - global gate bit 7 blocks all sources when clear, else per-source masks
// - main enable bit 6 is a scratch flag with no hardware effect
// - main enable bits 5..0 pass timer2, uart0, timer1, pin1, timer0, pin0
// - main enable at 0xa8, all pages, bit access, resets to zero
// - priority bits 5..0 set high or low level of the six classic sources
// - priority bits 7..6 read as ones, writes to them ignored
// - priority register at 0xb8, all pages, bit access, resets to 0xc0
// - extended enable one bits 6..4 pass comparator 2, 1, 0 requests
// - extended enable one bits 3..0 pass counter array, window, twowire, spi
// - extended enable one bit 7 reads zero, writes ignored
// - extended enable one at 0xe6, all pages, resets to zero
// - extended enable two bits 6,5 pass uart1 and can requests
// - extended enable two bits 2..0 pass timer4, conv0 done, timer3
// - extended enable two bits 4,3 gate second converter, variant only
// - extended enable two at 0xe7, all pages, bit 7 reserved, resets zero
// - high request preempts low service; high service never preempted
// - equal level requests resolved by fixed source order
// - pending enabled requests sampled and decoded every clock
module imp_regs
   import imp_pkg::*;
#(
   parameter bit HAS_CONV_TWO = 1'b1
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         rst,
   // register access from the core
   input  wire imp_sfr_req_t sfrReq,
   output var  logic [7:0]   sfrRdData,
   output var  logic         sfrRdHit,
   // pending flags, index equals fixed source order
   input  wire logic [19:0]  pendIn,
   // service handshake with the sequencer
   input  wire logic         svcAck,
   input  wire logic         svcDone,
   // request toward the sequencer
   output var  imp_irq_t     irqOut,
   output var  logic [1:0]   svcLevel
);

   // narrow parts keep the second converter bits at zero
   localparam logic [7:0] WMASK_EXT2 = HAS_CONV_TWO ?
      `IMP_WMASK_ENEXT2 : (`IMP_WMASK_ENEXT2 & ~`IMP_CONV2_BITS);

   // byte write then bit write to one register
   function automatic logic [7:0] wr_byte(
      input logic [7:0]   cur,
      input logic [7:0]   adr,
      input logic [7:0]   wmask,
      input imp_sfr_req_t q
   );
      logic [7:0] v;
      v = cur;
      if (q.wr && q.addr == adr) begin
         v = (cur & ~wmask) | (q.data & wmask);
      end
      // bit addresses only alias registers on 8-aligned addresses
      if (q.bitWr && {q.addr[7:3], 3'h0} == adr &&
          wmask[q.addr[2:0]]) begin
         v[q.addr[2:0]] = q.data[0];
      end
      return v;
   endfunction

   // lowest set index wins, found flag on top
   function automatic logic [5:0] first_set(input logic [19:0] v);
      logic [5:0] r;
      r = 6'h00;
      // downward scan so the lowest index is written last
      for (int i = `IMP_NUM_SRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction

   imp_en_main_t  enMain;
   imp_pri_main_t priMain;
   imp_en_ext1_t  enExt1;
   imp_en_ext2_t  enExt2;
   imp_en_main_t  next_enMain;
   imp_pri_main_t next_priMain;
   imp_en_ext1_t  next_enExt1;
   imp_en_ext2_t  next_enExt2;

   // register writes
   always_comb begin
      next_enMain  = imp_en_main_t'(wr_byte(enMain, `IMP_ADDR_ENMAIN,
                                            `IMP_WMASK_ENMAIN, sfrReq));
      next_priMain = imp_pri_main_t'(wr_byte(priMain, `IMP_ADDR_PRIMAIN,
                                             `IMP_WMASK_PRIMAIN, sfrReq));
      next_priMain.unused = 2'h3;
      next_enExt1  = imp_en_ext1_t'(wr_byte(enExt1, `IMP_ADDR_ENEXT1,
                                            `IMP_WMASK_ENEXT1, sfrReq));
      // second converter bits only on variants
      next_enExt2  = imp_en_ext2_t'(wr_byte(enExt2, `IMP_ADDR_ENEXT2,
                                            WMASK_EXT2, sfrReq));
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enMain  <= imp_en_main_t'(`IMP_RST_ENMAIN);
         priMain <= imp_pri_main_t'(`IMP_RST_PRIMAIN);
         enExt1  <= imp_en_ext1_t'(`IMP_RST_ENEXT1);
         enExt2  <= imp_en_ext2_t'(`IMP_RST_ENEXT2);
      end else begin
         enMain  <= next_enMain;
         priMain <= next_priMain;
         enExt1  <= next_enExt1;
         enExt2  <= next_enExt2;
      end
   end

   // read path
   logic [7:0] next_sfrRdData;
   logic       next_sfrRdHit;
   logic [7:0] rdByte;
   logic       rdMatch;
   logic [7:0] rdAddr;

   always_comb begin
      // bit reads use the byte address of their register
      rdAddr  = sfrReq.bitRd ? {sfrReq.addr[7:3], 3'h0} : sfrReq.addr;
      rdByte  = 8'h00;
      rdMatch = 1'b1;
      unique case (rdAddr)
         `IMP_ADDR_ENMAIN:  rdByte = enMain;
         `IMP_ADDR_PRIMAIN: rdByte = priMain | `IMP_RDONE_PRIMAIN;
         `IMP_ADDR_ENEXT1:  rdByte = enExt1 & `IMP_WMASK_ENEXT1;
         `IMP_ADDR_ENEXT2:  rdByte = enExt2 & `IMP_WMASK_ENEXT2;
         default:           rdMatch = 1'b0;
      endcase
      // other addresses belong to other blocks, answer zero
      next_sfrRdData = 8'h00;
      next_sfrRdHit  = 1'b0;
      if (sfrReq.bitRd && rdMatch &&
          (rdAddr == `IMP_ADDR_ENMAIN || rdAddr == `IMP_ADDR_PRIMAIN)) begin
         // bit reads return the addressed bit in bit 0
         next_sfrRdData = {7'h00, rdByte[sfrReq.addr[2:0]]};
         next_sfrRdHit  = 1'b1;
      end else if (sfrReq.rd && !sfrReq.bitRd && rdMatch) begin
         next_sfrRdData = rdByte;
         next_sfrRdHit  = 1'b1;
      end
   end

   // read answer stands for one cycle only
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         sfrRdData <= 8'h00;
         sfrRdHit  <= 1'b0;
      end else begin
         sfrRdData <= next_sfrRdData;
         sfrRdHit  <= next_sfrRdHit;
      end
   end

   // gating
   // a plain and of flag, mask and gate: a write counts from the next edge
   logic [19:0] enVec;
   logic [19:0] lvlVec;
   logic [19:0] passVec;
   logic [5:0]  pickHigh;
   logic [5:0]  pickLow;

   always_comb begin
      // classic masks, scratch bit 6 gates nothing
      enVec[0]  = enMain.extPinZeroMask;
      enVec[1]  = enMain.timerZeroMask;
      enVec[2]  = enMain.extPinOneMask;
      enVec[3]  = enMain.timerOneMask;
      enVec[4]  = enMain.uartZeroMask;
      enVec[5]  = enMain.timerTwoMask;
      enVec[6]  = enExt1.serialPeriphMask;
      enVec[7]  = enExt1.twowireBusMask;
      enVec[8]  = enExt1.convZeroWindowMask;
      enVec[9]  = enExt1.counterArrayMask;
      enVec[10] = enExt1.comparatorZeroMask;
      enVec[11] = enExt1.comparatorOneMask;
      enVec[12] = enExt1.comparatorTwoMask;
      // timer three, conv0 done, timer four
      enVec[13] = enExt2.timerThreeMask;
      enVec[14] = enExt2.convZeroDoneMask;
      enVec[15] = enExt2.timerFourMask;
      // second converter pair, zero mask on narrow parts
      enVec[16] = enExt2.convTwoWindowMask;
      enVec[17] = enExt2.convTwoDoneMask;
      enVec[18] = enExt2.canCtrlMask;
      enVec[19] = enExt2.uartOneMask;
      // classic levels; extended sources stay low here
      // extended priority bits are not part of this bank
      lvlVec    = 20'h00000;
      lvlVec[0] = priMain.extPinZeroLevel;
      lvlVec[1] = priMain.timerZeroLevel;
      lvlVec[2] = priMain.extPinOneLevel;
      lvlVec[3] = priMain.timerOneLevel;
      lvlVec[4] = priMain.uartZeroLevel;
      lvlVec[5] = priMain.timerTwoLevel;
      // pending, mask and global gate all required
      passVec = pendIn & enVec & {20{enMain.globalIrqGate}};
      pickHigh = first_set(passVec & lvlVec);
      pickLow  = first_set(passVec & ~lvlVec);
   end

   // service tracking and request
   imp_svc_t   svcState;
   imp_svc_t   next_svcState;
   imp_irq_t   next_irqOut;
   logic [1:0] next_svcLevel;
   logic       highOk;
   logic       lowOk;

   always_comb begin
      // ack and done pulses come from the sequencer, one per routine
      next_svcState = svcState;
      // nesting of high over low only
      unique case (svcState)
         SVC_NONE: begin
            if (svcAck && irqOut.req) begin
               next_svcState = irqOut.high ? SVC_HIGH : SVC_LOW;
            end
         end
         SVC_LOW: begin
            if (svcDone) begin
               next_svcState = SVC_NONE;
            // only a high request may nest over a low routine
            end else if (svcAck && irqOut.req && irqOut.high) begin
               next_svcState = SVC_NEST;
            end
         end
         SVC_HIGH: begin
            // a high routine ends only by its own return
            if (svcDone) begin
               next_svcState = SVC_NONE;
            end
         end
         SVC_NEST: begin
            // leaving the nested routine resumes the low one
            if (svcDone) begin
               next_svcState = SVC_LOW;
            end
         end
         default: next_svcState = SVC_NONE;
      endcase
   end

   always_comb begin
      // judged on the state after this edge, so an acked
      // request is not shown again beside its own level flag
      highOk = (next_svcState == SVC_NONE) || (next_svcState == SVC_LOW);
      lowOk  = (next_svcState == SVC_NONE);
      next_irqOut = '0;
      // decode each clock from current registers
      if (pickHigh[5] && highOk) begin
         next_irqOut = '{req: 1'b1, high: 1'b1, idx: pickHigh[4:0]};
      end else if (pickLow[5] && lowOk) begin
         next_irqOut = '{req: 1'b1, high: 1'b0, idx: pickLow[4:0]};
      end
      // level flags follow the state the bank moves to
      // bit 1 high routine, bit 0 low routine
      next_svcLevel = 2'b00;
      unique case (next_svcState)
         SVC_NONE: next_svcLevel = 2'b00;
         SVC_LOW:  next_svcLevel = 2'b01;
         SVC_HIGH: next_svcLevel = 2'b10;
         SVC_NEST: next_svcLevel = 2'b11;
      endcase
   end

   // request and level flags registered together so they agree
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         svcState <= SVC_NONE;
         irqOut   <= '0;
         svcLevel <= 2'h0;
      end else begin
         svcState <= next_svcState;
         irqOut   <= next_irqOut;
         svcLevel <= next_svcLevel;
      end
   end

endmodule
`default_nettype wire

// ---- src/imp_params.svh ----
// register addresses, write masks, reset values and field positions
`ifndef IMP_PARAMS_SVH
`define IMP_PARAMS_SVH
`define IMP_ADDR_ENMAIN  8'ha8
`define IMP_ADDR_PRIMAIN 8'hb8
`define IMP_ADDR_ENEXT1  8'he6
`define IMP_ADDR_ENEXT2  8'he7
`define IMP_RST_ENMAIN   8'h00
`define IMP_RST_PRIMAIN  8'hc0
`define IMP_RST_ENEXT1   8'h00
`define IMP_RST_ENEXT2   8'h00
`define IMP_WMASK_ENMAIN  8'hff
`define IMP_WMASK_PRIMAIN 8'h3f
`define IMP_WMASK_ENEXT1  8'h7f
`define IMP_WMASK_ENEXT2  8'h7f
`define IMP_CONV2_BITS    8'h18
`define IMP_RDONE_PRIMAIN 8'hc0
`define IMP_NUM_SRC       20
`define IMP_NUM_CLASSIC   6
`endif

// ---- src/imp_pkg.sv ----
// types shared by the interrupt mask and priority register bank
package imp_pkg;
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic       bitWr;
      logic       bitRd;
      logic [7:0] addr;
      logic [7:0] data;
   } imp_sfr_req_t;

   typedef struct packed {
      logic       req;
      logic       high;
      logic [4:0] idx;
   } imp_irq_t;

   typedef struct packed {
      logic globalIrqGate;
      logic softwareScratchFlag;
      logic timerTwoMask;
      logic uartZeroMask;
      logic timerOneMask;
      logic extPinOneMask;
      logic timerZeroMask;
      logic extPinZeroMask;
   } imp_en_main_t;

   typedef struct packed {
      logic [1:0] unused;
      logic       timerTwoLevel;
      logic       uartZeroLevel;
      logic       timerOneLevel;
      logic       extPinOneLevel;
      logic       timerZeroLevel;
      logic       extPinZeroLevel;
   } imp_pri_main_t;

   typedef struct packed {
      logic reserved;
      logic comparatorTwoMask;
      logic comparatorOneMask;
      logic comparatorZeroMask;
      logic counterArrayMask;
      logic convZeroWindowMask;
      logic twowireBusMask;
      logic serialPeriphMask;
   } imp_en_ext1_t;

   typedef struct packed {
      logic reserved;
      logic uartOneMask;
      logic canCtrlMask;
      logic convTwoDoneMask;
      logic convTwoWindowMask;
      logic timerFourMask;
      logic convZeroDoneMask;
      logic timerThreeMask;
   } imp_en_ext2_t;

   typedef enum logic [3:0] {
      SVC_NONE = 4'b0001,
      SVC_LOW  = 4'b0010,
      SVC_HIGH = 4'b0100,
      SVC_NEST = 4'b1000
   } imp_svc_t;
endpackage

// ---- sim/imp_regs_monitor.sv ----
// assertion checker for the interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module imp_regs_monitor
   import imp_pkg::*;
(
   // all ports of the bank
   input wire logic         core_clk,
   input wire logic         rst,
   input wire imp_sfr_req_t sfrReq,
   input wire logic [7:0]   sfrRdData,
   input wire logic         sfrRdHit,
   input wire logic [19:0]  pendIn,
   input wire logic         svcAck,
   input wire logic         svcDone,
   input wire imp_irq_t     irqOut,
   input wire logic [1:0]   svcLevel
);
   logic [19:0] pendQ;
   logic        rdByte;
   // pending flags as the bank saw them one edge ago
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) pendQ <= 20'h00000;
      else pendQ <= pendIn;
   end
   assign rdByte = sfrReq.rd && !sfrReq.bitRd;
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   AST_GATE: assert property (irqOut.req |-> pendQ[irqOut.idx])
      else $error("request without pending flag");
   AST_RDHIT: assert property (sfrRdHit |-> $past(sfrReq.rd | sfrReq.bitRd))
      else $error("read hit without read");
   AST_UNMAP: assert property (rdByte && !(sfrReq.addr inside
      {8'ha8, 8'hb8, 8'he6, 8'he7}) |=> !sfrRdHit && sfrRdData == 8'h00)
      else $error("unmapped read answered");
   AST_PRI_TOP: assert property (rdByte && sfrReq.addr == 8'hb8
      |=> sfrRdHit && sfrRdData[7:6] == 2'b11)
      else $error("priority top bits not ones");
   AST_EXT_TOP: assert property (rdByte && sfrReq.addr[7:1] == 7'h73
      |=> sfrRdHit && !sfrRdData[7])
      else $error("reserved bit reads one");
   AST_GLOBAL: assert property (sfrReq.wr && !sfrReq.bitWr
      && sfrReq.addr == 8'ha8 && !sfrReq.data[7] |-> ##2 !irqOut.req)
      else $error("request with global gate clear");
   AST_HIGHBLK: assert property (svcLevel[1] |-> !irqOut.req)
      else $error("high routine preempted");
   AST_LOWBLK: assert property (svcLevel[0] && irqOut.req |-> irqOut.high)
      else $error("low request during service");
   AST_ACKHI: assert property (svcAck && irqOut.req && irqOut.high
      |=> svcLevel[1] && !irqOut.req)
      else $error("high ack not tracked");
   cover property (irqOut.req && irqOut.high);
   cover property (svcLevel == 2'b11);
   cover property (sfrRdHit);
endmodule
bind imp_regs imp_regs_monitor mon (.core_clk, .rst, .sfrReq, .sfrRdData,
   .sfrRdHit, .pendIn, .svcAck, .svcDone, .irqOut, .svcLevel);
`default_nettype wire

// ---- sim/imp_seq_model.sv ----
// sequencer stand-in that vectors after a set delay
`timescale 1ns/1ps
`default_nettype none
module imp_seq_model
   import imp_pkg::*;
(
   // clock and reset
   input  wire logic       core_clk,
   input  wire logic       rst,
   // request and test controls
   input  wire imp_irq_t   irqOut,
   input  wire logic       ackEn,
   input  wire logic [3:0] ackDelay,
   input  wire logic       retReq,
   // handshake back to the bank
   output var  logic       svcAck,
   output var  logic       svcDone
);
   logic [3:0] waitCnt;
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         waitCnt <= 4'h0;
         svcAck <= 1'b0;
         svcDone <= 1'b0;
      end else begin
         svcDone <= retReq;
         svcAck <= 1'b0;
         if (ackEn && irqOut.req && !svcAck) begin
            // no second ack while the first is still landing
            if (waitCnt == ackDelay) begin
               svcAck <= 1'b1;
               waitCnt <= 4'h0;
            end else waitCnt <= waitCnt + 4'h1;
         end else waitCnt <= 4'h0;
      end
   end
endmodule
`default_nettype wire

// ---- sim/tb.sv ----
// self-checking bench for the interrupt register bank
`timescale 1ns/1ps
`default_nettype none
module tb;
   import imp_pkg::*;
   logic         core_clk = 1'b0;
   logic         rst = 1'b1;
   logic         ackEn = 1'b0;
   logic         retReq = 1'b0;
   logic [3:0]   ackDelay = 4'h0;
   imp_sfr_req_t sfrReq = '0;
   logic [19:0]  pendIn = 20'h00000;
   logic [7:0]   sfrRdData;
   logic         sfrRdHit, svcAck, svcDone;
   imp_irq_t     irqOut;
   logic [1:0]   svcLevel;
   int           nErrors = 0;
   int           checksDone = 0;
   always #2.5 core_clk = ~core_clk;
   imp_regs dut (.core_clk, .rst, .sfrReq, .sfrRdData, .sfrRdHit, .pendIn,
      .svcAck, .svcDone, .irqOut, .svcLevel);
   imp_seq_model seq (.core_clk, .rst, .irqOut, .ackEn, .ackDelay, .retReq,
      .svcAck, .svcDone);
   task automatic chk(input logic [7:0] got, exp);
      checksDone++;
      if (got !== exp) begin
         nErrors++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic final_report;
      $display("errors %0d checks %0d", nErrors, checksDone);
      if (nErrors == 0 && checksDone > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // kind bits are wr, rd, bitWr, bitRd
   // request left up, so back to back ops change it once per step
   task automatic op(input logic [3:0] k, input logic [7:0] a, d);
      sfrReq = {k, a, d};
      @(negedge core_clk);
   endtask
   // write then one idle edge, so the gating has caught up
   task automatic wr1(input logic [3:0] k, input logic [7:0] a, d);
      op(k, a, d);
      sfrReq = '0;
      @(negedge core_clk);
   endtask
   task automatic rd(input logic [7:0] a, e, input logic h);
      op(4'h4, a, 8'h00);
      chk(sfrRdData, e);
      chk({7'h0, sfrRdHit}, {7'h0, h});
   endtask
   task automatic setm(input logic g, input logic [19:0] m);
      op(4'h8, 8'ha8, {g, 1'b0, m[5:0]});
      op(4'h8, 8'he6, {1'b0, m[12:6]});
      op(4'h8, 8'he7, {1'b0, m[19:13]});
      sfrReq = '0;
      @(negedge core_clk);
   endtask
   task automatic irq(input logic r, h, input logic [4:0] i);
      if (r) chk({1'b0, irqOut}, {2'b01, h, i});
      else chk({7'h0, irqOut.req}, 8'h00);
   endtask
   task automatic ack(input logic [1:0] lv);
      int n;
      ackEn = 1'b1;
      for (n = 0; n < 40 && svcAck !== 1'b1; n++) @(negedge core_clk);
      ackEn = 1'b0;
      if (n == 40) begin
         nErrors++;
         final_report();
      end
      @(negedge core_clk);
      chk({6'h0, svcLevel}, {6'h0, lv});
   endtask
   task automatic ret(input logic [1:0] lv);
      retReq = 1'b1;
      @(negedge core_clk);
      retReq = 1'b0;
      @(negedge core_clk);
      chk({6'h0, svcLevel}, {6'h0, lv});
      @(negedge core_clk);
   endtask
   task automatic t_reset;
      rd(8'ha8, 8'h00, 1'b1);
      rd(8'hb8, 8'hc0, 1'b1);
      rd(8'he6, 8'h00, 1'b1);
      rd(8'he7, 8'h00, 1'b1);
      rd(8'h80, 8'h00, 1'b0);
   endtask
   task automatic t_rw;
      pendIn = 20'hfffff;
      op(4'h8, 8'ha8, 8'h40);
      rd(8'ha8, 8'h40, 1'b1);
      irq(1'b0, 1'b0, 5'h0);
      op(4'h8, 8'hb8, 8'h00);
      rd(8'hb8, 8'hc0, 1'b1);
      op(4'h8, 8'he6, 8'hff);
      rd(8'he6, 8'h7f, 1'b1);
      op(4'h8, 8'he7, 8'hff);
      rd(8'he7, 8'h7f, 1'b1);
      op(4'h2, 8'haf, 8'h01);
      rd(8'ha8, 8'hc0, 1'b1);
      op(4'h1, 8'haf, 8'h00);
      chk(sfrRdData, 8'h01);
      chk({7'h0, sfrRdHit}, 8'h01);
      op(4'h2, 8'haf, 8'h00);
      rd(8'ha8, 8'h40, 1'b1);
   endtask
   task automatic t_mask;
      for (int i = 0; i < 20; i++) begin
         pendIn = 20'h1 << i;
         setm(1'b1, 20'h1 << i);
         irq(1'b1, 1'b0, 5'(i));
         setm(1'b1, ~(20'h1 << i));
         irq(1'b0, 1'b0, 5'h0);
         setm(1'b0, 20'hfffff);
         irq(1'b0, 1'b0, 5'h0);
      end
   endtask
   task automatic t_prio;
      pendIn = 20'hfffff;
      setm(1'b1, 20'hfffff);
      irq(1'b1, 1'b0, 5'h0);
      wr1(4'h2, 8'hbd, 8'h01);
      irq(1'b1, 1'b1, 5'h5);
      ack(2'b10);
      irq(1'b0, 1'b0, 5'h0);
      ret(2'b00);
      irq(1'b1, 1'b1, 5'h5);
      wr1(4'h8, 8'hb8, 8'h00);
      ackDelay = 4'h5;
      ack(2'b01);
      irq(1'b0, 1'b0, 5'h0);
      wr1(4'h2, 8'hba, 8'h01);
      irq(1'b1, 1'b1, 5'h2);
      ack(2'b11);
      ret(2'b01);
   endtask
   initial begin
      repeat (8) @(posedge core_clk);
      @(negedge core_clk);
      rst = 1'b0;
      t_reset();
      t_rw();
      t_mask();
      t_prio();
      final_report();
   end
endmodule
`default_nettype wire
